// file: hw/ovm_regs.sv
// Purpose: right speaker mixer attenuation and headphone/line output level registers
// Assumes: single core_clk domain, register port driven from the same clock
// Notes:   staged gain is what reads back; live gain moves only on a commit write
//
// Behaviour
// R1: four right speaker mixer attenuation bits, set means -6dB, reset clear
// R2: mute at bit 8 of each output register, reset un-muted
// R3: six-bit gain code, 000000 is -57dB, 1dB steps, 111001 is 0dB
// R4: headphone gain fields reset to 10_1101
// R5: line gain fields reset to 11_1001, the 0dB code
// R6: commit bit 7 on either headphone register applies both headphone gains together
// R7: commit bit 7 on either line register applies both line gains together
// R8: zero-cross enable at bit 6 per output, reset disabled
// R9: gain written without commit is staged; live gain holds until a commit
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module ovm_regs (
  input  wire logic                        core_clk,
  input  wire logic                        nrst,
  input  wire logic [ovm_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [ovm_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [ovm_pkg::DATA_W-1:0]  reg_rdata,
  output logic                             left_dac_to_right_spk_atten,
  output logic                             right_dac_to_right_spk_atten,
  output logic                             left_bypass_to_right_spk_atten,
  output logic                             right_bypass_to_right_spk_atten,
  output logic                             left_phones_silence,
  output logic                             right_phones_silence,
  output logic                             left_line_silence,
  output logic                             right_line_silence,
  output logic                             left_phones_zero_cross_en,
  output logic                             right_phones_zero_cross_en,
  output logic                             left_line_zero_cross_en,
  output logic                             right_line_zero_cross_en,
  output logic      [ovm_pkg::GAIN_W-1:0]  left_phones_gain,
  output logic      [ovm_pkg::GAIN_W-1:0]  right_phones_gain,
  output logic      [ovm_pkg::GAIN_W-1:0]  left_line_gain,
  output logic      [ovm_pkg::GAIN_W-1:0]  right_line_gain
);

  ////////////////////////////////////////////////////////////////////////////
  // state: index 0 hp left, 1 hp right, 2 line left, 3 line right
  logic [ovm_pkg::ATTEN_W-1:0] atten_r,   atten_nxt;
  logic [3:0]                  mute_r,    mute_nxt;
  logic [3:0]                  zc_r,      zc_nxt;
  logic [ovm_pkg::GAIN_W-1:0]  stage_r [4];
  logic [ovm_pkg::GAIN_W-1:0]  stage_nxt [4];
  logic [ovm_pkg::GAIN_W-1:0]  live_r [4];
  logic [ovm_pkg::GAIN_W-1:0]  live_nxt [4];
  logic [ovm_pkg::DATA_W-1:0]  rdata_r,   rdata_nxt;
  logic [3:0]                  sel;
  logic                        hp_commit;
  logic                        line_commit;

  always_comb begin
    sel = 4'h0;
    if (reg_addr == ovm_pkg::ADDR_HP_LEFT) begin
      sel = 4'h1;
    end else if (reg_addr == ovm_pkg::ADDR_HP_RIGHT) begin
      sel = 4'h2;
    end else if (reg_addr == ovm_pkg::ADDR_LINE_LEFT) begin
      sel = 4'h4;
    end else if (reg_addr == ovm_pkg::ADDR_LINE_RIGHT) begin
      sel = 4'h8;
    end
  end

  assign hp_commit   = reg_wr && (|sel[1:0]) && reg_wdata[ovm_pkg::COMMIT_BIT]; // R6
  assign line_commit = reg_wr && (|sel[3:2]) && reg_wdata[ovm_pkg::COMMIT_BIT]; // R7

  ////////////////////////////////////////////////////////////////////////////
  // write path
  always_comb begin
    atten_nxt = atten_r;
    mute_nxt  = mute_r;
    zc_nxt    = zc_r;
    for (int i = 0; i < 4; i++) begin
      stage_nxt[i] = stage_r[i];
      live_nxt[i]  = live_r[i];
    end
    if (reg_wr && reg_addr == ovm_pkg::ADDR_SPK_ATTEN) begin
      atten_nxt = reg_wdata[ovm_pkg::ATTEN_W-1:0]; // R1
    end
    for (int i = 0; i < 4; i++) begin
      if (reg_wr && sel[i]) begin
        mute_nxt[i]  = reg_wdata[ovm_pkg::MUTE_BIT]; // R2
        zc_nxt[i]    = reg_wdata[ovm_pkg::ZC_BIT]; // R8
        stage_nxt[i] = reg_wdata[ovm_pkg::GAIN_W-1:0]; // R3 R9
      end
    end
    // the pair moves together, and a commit write's own gain counts as staged
    if (hp_commit) begin
      live_nxt[0] = stage_nxt[0]; // R6
      live_nxt[1] = stage_nxt[1]; // R6
    end
    if (line_commit) begin
      live_nxt[2] = stage_nxt[2]; // R7
      live_nxt[3] = stage_nxt[3]; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: unmapped reads return zero, commit bit reads zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == ovm_pkg::ADDR_SPK_ATTEN) begin
        rdata_nxt = {12'h000, atten_r};
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (sel[i]) begin
            rdata_nxt = {7'h00, mute_r[i], 1'b0, zc_r[i], stage_r[i]};
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      atten_r    <= ovm_pkg::ATTEN_RST; // R1
      mute_r     <= 4'h0; // R2
      zc_r       <= 4'h0; // R8
      stage_r[0] <= ovm_pkg::HP_GAIN_RST; // R4
      stage_r[1] <= ovm_pkg::HP_GAIN_RST; // R4
      stage_r[2] <= ovm_pkg::LINE_GAIN_RST; // R5
      stage_r[3] <= ovm_pkg::LINE_GAIN_RST; // R5
      live_r[0]  <= ovm_pkg::HP_GAIN_RST; // R4
      live_r[1]  <= ovm_pkg::HP_GAIN_RST; // R4
      live_r[2]  <= ovm_pkg::LINE_GAIN_RST; // R5
      live_r[3]  <= ovm_pkg::LINE_GAIN_RST; // R5
      rdata_r    <= 16'h0000;
    end else begin
      atten_r <= atten_nxt;
      mute_r  <= mute_nxt;
      zc_r    <= zc_nxt;
      stage_r <= stage_nxt;
      live_r  <= live_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata                       = rdata_r;
  assign right_bypass_to_right_spk_atten = atten_r[0];
  assign left_bypass_to_right_spk_atten  = atten_r[1];
  assign right_dac_to_right_spk_atten    = atten_r[2];
  assign left_dac_to_right_spk_atten     = atten_r[3];
  assign left_phones_silence             = mute_r[0];
  assign right_phones_silence            = mute_r[1];
  assign left_line_silence               = mute_r[2];
  assign right_line_silence              = mute_r[3];
  assign left_phones_zero_cross_en       = zc_r[0];
  assign right_phones_zero_cross_en      = zc_r[1];
  assign left_line_zero_cross_en         = zc_r[2];
  assign right_line_zero_cross_en        = zc_r[3];
  assign left_phones_gain                = live_r[0];
  assign right_phones_gain               = live_r[1];
  assign left_line_gain                  = live_r[2];
  assign right_line_gain                 = live_r[3];

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_atten_write: assert property (@(posedge core_clk) disable iff (!nrst) // R1
    reg_wr && reg_addr == ovm_pkg::ADDR_SPK_ATTEN |=>
      left_dac_to_right_spk_atten == $past(reg_wdata[3]) &&
      right_bypass_to_right_spk_atten == $past(reg_wdata[0]))
    else $error("attenuation bits did not follow write");

  a_mute_write: assert property (@(posedge core_clk) disable iff (!nrst) // R2
    reg_wr && reg_addr == ovm_pkg::ADDR_LINE_RIGHT |=>
      right_line_silence == $past(reg_wdata[8]))
    else $error("line right mute did not follow write");

  a_gain_hold: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    !hp_commit |=> $stable(left_phones_gain) && $stable(right_phones_gain))
    else $error("headphone gain moved without commit");

  a_line_hold: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    !line_commit |=> $stable(left_line_gain) && $stable(right_line_gain))
    else $error("line gain moved without commit");

  a_hp_commit: assert property (@(posedge core_clk) disable iff (!nrst) // R6
    reg_wr && reg_addr == ovm_pkg::ADDR_HP_RIGHT && reg_wdata[7] |=>
      right_phones_gain == $past(reg_wdata[5:0]) && left_phones_gain == stage_r[0])
    else $error("headphone pair not committed together");

  a_line_commit: assert property (@(posedge core_clk) disable iff (!nrst) // R7
    reg_wr && reg_addr == ovm_pkg::ADDR_LINE_LEFT && reg_wdata[7] |=>
      left_line_gain == $past(reg_wdata[5:0]) && right_line_gain == stage_r[3])
    else $error("line pair not committed together");

  a_zc_write: assert property (@(posedge core_clk) disable iff (!nrst) // R8
    reg_wr && reg_addr == ovm_pkg::ADDR_HP_LEFT |=>
      left_phones_zero_cross_en == $past(reg_wdata[6]))
    else $error("zero cross enable did not follow write");

  a_read_stage: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    reg_rd && reg_addr == ovm_pkg::ADDR_HP_LEFT |=>
      reg_rdata[5:0] == $past(stage_r[0]) && reg_rdata[7] == 1'b0)
    else $error("headphone read data wrong");

  a_read_idle: assert property (@(posedge core_clk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");

  a_read_unmapped: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_rd && sel == 4'h0 && reg_addr != ovm_pkg::ADDR_SPK_ATTEN |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");

  a_read_atten: assert property (@(posedge core_clk) disable iff (!nrst) // R1
    reg_rd && reg_addr == ovm_pkg::ADDR_SPK_ATTEN |=>
      reg_rdata == {12'h000, $past({left_dac_to_right_spk_atten, right_dac_to_right_spk_atten,
                                    left_bypass_to_right_spk_atten,
                                    right_bypass_to_right_spk_atten})})
    else $error("attenuation read data wrong");

  // reset values are seen on the first edge with reset released, before any write lands
  a_hp_reset_gain: assert property (@(posedge core_clk) disable iff (!nrst) // R4
    $rose(nrst) |->
      left_phones_gain == ovm_pkg::HP_GAIN_RST &&
      right_phones_gain == ovm_pkg::HP_GAIN_RST)
    else $error("headphone gain not at reset code");

  a_line_reset_gain: assert property (@(posedge core_clk) disable iff (!nrst) // R5
    $rose(nrst) |->
      left_line_gain == ovm_pkg::LINE_GAIN_RST &&
      right_line_gain == ovm_pkg::LINE_GAIN_RST)
    else $error("line gain not at reset code");

  a_atten_reset: assert property (@(posedge core_clk) disable iff (!nrst) // R1
    $rose(nrst) |->
      {left_dac_to_right_spk_atten, right_dac_to_right_spk_atten,
       left_bypass_to_right_spk_atten, right_bypass_to_right_spk_atten} == ovm_pkg::ATTEN_RST)
    else $error("attenuation not clear after reset");

  a_mute_reset: assert property (@(posedge core_clk) disable iff (!nrst) // R2
    $rose(nrst) |->
      {left_phones_silence, right_phones_silence,
       left_line_silence, right_line_silence} == 4'h0)
    else $error("outputs muted after reset");

  a_zc_reset: assert property (@(posedge core_clk) disable iff (!nrst) // R8
    $rose(nrst) |->
      {left_phones_zero_cross_en, right_phones_zero_cross_en,
       left_line_zero_cross_en, right_line_zero_cross_en} == 4'h0)
    else $error("zero cross enabled after reset");

  a_atten_hold: assert property (@(posedge core_clk) disable iff (!nrst) // R1
    !(reg_wr && reg_addr == ovm_pkg::ADDR_SPK_ATTEN) |=>
      $stable({left_dac_to_right_spk_atten, right_dac_to_right_spk_atten,
               left_bypass_to_right_spk_atten, right_bypass_to_right_spk_atten}))
    else $error("attenuation moved without write");

  a_atten_mid: assert property (@(posedge core_clk) disable iff (!nrst) // R1
    reg_wr && reg_addr == ovm_pkg::ADDR_SPK_ATTEN |=>
      right_dac_to_right_spk_atten == $past(reg_wdata[2]) &&
      left_bypass_to_right_spk_atten == $past(reg_wdata[1]))
    else $error("middle attenuation bits did not follow write");

  a_gain_field: assert property (@(posedge core_clk) disable iff (!nrst) // R3
    reg_wr && reg_addr == ovm_pkg::ADDR_HP_RIGHT |=>
      stage_r[1] == $past(reg_wdata[ovm_pkg::GAIN_W-1:0]))
    else $error("gain field not taken from low six bits");

  a_mute_hp_left: assert property (@(posedge core_clk) disable iff (!nrst) // R2
    reg_wr && reg_addr == ovm_pkg::ADDR_HP_LEFT |=>
      left_phones_silence == $past(reg_wdata[ovm_pkg::MUTE_BIT]))
    else $error("headphone left mute did not follow write");

  a_mute_hp_right: assert property (@(posedge core_clk) disable iff (!nrst) // R2
    reg_wr && reg_addr == ovm_pkg::ADDR_HP_RIGHT |=>
      right_phones_silence == $past(reg_wdata[ovm_pkg::MUTE_BIT]))
    else $error("headphone right mute did not follow write");

  a_mute_line_left: assert property (@(posedge core_clk) disable iff (!nrst) // R2
    reg_wr && reg_addr == ovm_pkg::ADDR_LINE_LEFT |=>
      left_line_silence == $past(reg_wdata[ovm_pkg::MUTE_BIT]))
    else $error("line left mute did not follow write");

  a_zc_hp_right: assert property (@(posedge core_clk) disable iff (!nrst) // R8
    reg_wr && reg_addr == ovm_pkg::ADDR_HP_RIGHT |=>
      right_phones_zero_cross_en == $past(reg_wdata[ovm_pkg::ZC_BIT]))
    else $error("headphone right zero cross did not follow write");

  a_zc_line_left: assert property (@(posedge core_clk) disable iff (!nrst) // R8
    reg_wr && reg_addr == ovm_pkg::ADDR_LINE_LEFT |=>
      left_line_zero_cross_en == $past(reg_wdata[ovm_pkg::ZC_BIT]))
    else $error("line left zero cross did not follow write");

  a_zc_line_right: assert property (@(posedge core_clk) disable iff (!nrst) // R8
    reg_wr && reg_addr == ovm_pkg::ADDR_LINE_RIGHT |=>
      right_line_zero_cross_en == $past(reg_wdata[ovm_pkg::ZC_BIT]))
    else $error("line right zero cross did not follow write");

  // the other half of each pair: a commit from the opposite register
  a_hp_commit_left: assert property (@(posedge core_clk) disable iff (!nrst) // R6
    reg_wr && reg_addr == ovm_pkg::ADDR_HP_LEFT && reg_wdata[7] |=>
      left_phones_gain == $past(reg_wdata[5:0]) && right_phones_gain == stage_r[1])
    else $error("headphone pair not committed from left");

  a_line_commit_right: assert property (@(posedge core_clk) disable iff (!nrst) // R7
    reg_wr && reg_addr == ovm_pkg::ADDR_LINE_RIGHT && reg_wdata[7] |=>
      right_line_gain == $past(reg_wdata[5:0]) && left_line_gain == stage_r[2])
    else $error("line pair not committed from right");

  c_hp_commit:   cover property (@(posedge core_clk) disable iff (!nrst) hp_commit);
  c_line_commit: cover property (@(posedge core_clk) disable iff (!nrst) line_commit);
  c_stage_only:  cover property (@(posedge core_clk) disable iff (!nrst)
    reg_wr && sel[0] && !reg_wdata[7] ##2 hp_commit);
  c_line_stage:  cover property (@(posedge core_clk) disable iff (!nrst)
    reg_wr && sel[3] && !reg_wdata[7] ##2 line_commit);
  c_rst_release: cover property (@(posedge core_clk) disable iff (!nrst) $rose(nrst));
endmodule

// file: include/ovm_pkg.sv
// Purpose: constants for the output volume and mute register group
// Assumes: registers addressed by word index on a plain register port
// Notes:   update bit reads back as zero; it only acts on write
package ovm_pkg;
  localparam int                ADDR_W          = 8;
  localparam int                DATA_W          = 16;
  localparam logic [7:0]        ADDR_SPK_ATTEN  = 8'h37;
  localparam logic [7:0]        ADDR_HP_LEFT    = 8'h39;
  localparam logic [7:0]        ADDR_HP_RIGHT   = 8'h3a;
  localparam logic [7:0]        ADDR_LINE_LEFT  = 8'h3b;
  localparam logic [7:0]        ADDR_LINE_RIGHT = 8'h3c;
  localparam int                MUTE_BIT        = 8;
  localparam int                COMMIT_BIT      = 7;
  localparam int                ZC_BIT          = 6;
  localparam int                GAIN_W          = 6;
  localparam int                ATTEN_W         = 4;
  localparam logic [5:0]        HP_GAIN_RST     = 6'h2d;
  localparam logic [5:0]        LINE_GAIN_RST   = 6'h39;
  localparam logic [3:0]        ATTEN_RST       = 4'h0;
endpackage

// file: dv/ovm_regs_bench.sv
// Purpose: self-checking bench for the output volume and mute register group
// Assumes: one 25 MHz clock, register port driven on rising edges
// Notes:   read data sampled on the falling edge of the cycle after the strobe
`timescale 1ns/10ps
module ovm_regs_bench;
  logic        core_clk, nrst, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic        ldac, rdac, lbyp, rbyp, lps, rps, lls, rls, lpz, rpz, llz, rlz;
  logic [5:0]  lpg, rpg, llg, rlg;
  int          error_cnt, cmp_count, cyc;

  ovm_regs dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .left_dac_to_right_spk_atten(ldac), .right_dac_to_right_spk_atten(rdac),
    .left_bypass_to_right_spk_atten(lbyp), .right_bypass_to_right_spk_atten(rbyp),
    .left_phones_silence(lps), .right_phones_silence(rps),
    .left_line_silence(lls), .right_line_silence(rls),
    .left_phones_zero_cross_en(lpz), .right_phones_zero_cross_en(rpz),
    .left_line_zero_cross_en(llz), .right_line_zero_cross_en(rlz),
    .left_phones_gain(lpg), .right_phones_gain(rpg),
    .left_line_gain(llg), .right_line_gain(rlg));

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // strobe is dropped on the taking edge, so back-to-back calls never overlap
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check(name, reg_rdata, exp);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("phones gains", {4'h0, lpg, rpg}, {4'h0, ovm_pkg::HP_GAIN_RST, 6'h2d});
    check("line gains", {4'h0, llg, rlg}, {4'h0, 6'h39, 6'h39});
    check("mutes", {12'h000, lps, rps, lls, rls}, 16'h0000);
    check("zero cross", {12'h000, lpz, rpz, llz, rlz}, 16'h0000);
    check("atten", {12'h000, ldac, rdac, lbyp, rbyp}, 16'h0000);
    rd(ovm_pkg::ADDR_HP_RIGHT, 16'h002d, "phones right rd");
    rd(ovm_pkg::ADDR_LINE_LEFT, 16'h0039, "line left rd");
  endtask

  task automatic t_atten();
    wr(ovm_pkg::ADDR_SPK_ATTEN, 16'h000a);
    check("atten other bits", {12'h000, ldac, rdac, lbyp, rbyp}, 16'h000a);
    wr(ovm_pkg::ADDR_SPK_ATTEN, 16'hfff5);
    check("atten bits", {12'h000, ldac, rdac, lbyp, rbyp}, 16'h0005);
    rd(ovm_pkg::ADDR_SPK_ATTEN, 16'h0005, "atten rd");
  endtask

  task automatic t_phones();
    wr(ovm_pkg::ADDR_HP_LEFT, 16'h0010);
    check("staged only", {4'h0, lpg, rpg}, {4'h0, 6'h2d, 6'h2d});
    wr(ovm_pkg::ADDR_HP_RIGHT, 16'h0090);
    check("phones commit", {4'h0, lpg, rpg}, {4'h0, 6'h10, 6'h10});
    wr(ovm_pkg::ADDR_HP_LEFT, 16'h0140);
    check("phones mute zc", {12'h000, lps, rps, lpz, rpz}, 16'h000a);
    check("phones hold", {4'h0, lpg, rpg}, {4'h0, 6'h10, 6'h10});
    rd(ovm_pkg::ADDR_HP_RIGHT, 16'h0010, "commit reads 0");
  endtask

  task automatic t_line();
    wr(ovm_pkg::ADDR_LINE_RIGHT, 16'h003f);
    check("line staged", {4'h0, llg, rlg}, {4'h0, 6'h39, 6'h39});
    wr(ovm_pkg::ADDR_LINE_LEFT, 16'h01c0);
    check("line commit", {4'h0, llg, rlg}, {4'h0, 6'h00, 6'h3f});
    check("line mute zc", {12'h000, lls, rls, llz, rlz}, 16'h000a);
    wr(ovm_pkg::ADDR_LINE_RIGHT, 16'h0139);
    check("line right mute", {12'h000, lls, rls, llz, rlz}, 16'h000e);
    check("line hold", {10'h000, rlg}, 16'h003f);
    rd(ovm_pkg::ADDR_LINE_LEFT, 16'h0140, "line left rd");
  endtask

  task automatic t_swap();
    wr(ovm_pkg::ADDR_HP_LEFT, 16'h00bf);
    check("phones commit left", {4'h0, lpg, rpg}, {4'h0, 6'h3f, 6'h10});
    wr(ovm_pkg::ADDR_LINE_LEFT, 16'h0001);
    wr(ovm_pkg::ADDR_LINE_RIGHT, 16'h0080);
    check("line commit right", {4'h0, llg, rlg}, {4'h0, 6'h01, 6'h00});
    check("unmuted", {12'h000, lps, rps, lls, rls}, 16'h0000);
  endtask

  // second reset from a dirty state: everything must fall back to defaults
  task automatic t_rst_again();
    wr(ovm_pkg::ADDR_HP_LEFT, 16'h0155);
    check("pre reset mute zc", {12'h000, lps, rps, lpz, rpz}, 16'h000a);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    t_reset();
    rd(ovm_pkg::ADDR_HP_LEFT, 16'h002d, "phones left rd");
  endtask

  task automatic t_unmapped();
    wr(8'h38, 16'hffff);
    rd(8'h38, 16'h0000, "unmapped rd");
    check("atten kept", {12'h000, ldac, rdac, lbyp, rbyp}, 16'h0005);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // ceiling is far above the roughly fifty cycles the scenarios need
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    t_reset();
    t_atten();
    t_phones();
    t_line();
    t_swap();
    t_unmapped();
    t_rst_again();
    complete_run();
  end
endmodule
